// File: include/apc_pkg.sv
`default_nettype none

package apc_pkg;

    // ---------------------------------------------------------------
    // Word and pin layout
    // ---------------------------------------------------------------
    localparam int SAMPLE_W = 10;
    localparam int PIN_W    = 7;

    // Bit positions of the static control pins in the filtered vector.
    localparam int PIN_PD   = 0;
    localparam int PIN_SLP  = 1;
    localparam int PIN_FMT  = 2;
    localparam int PIN_OE   = 3;
    localparam int PIN_CKEN = 4;
    localparam int PIN_BLO  = 5;
    localparam int PIN_BHI  = 6;

    // Reset view of the pins: powered down, awake, offset binary,
    // data drivers and clock driver released.
    localparam logic [PIN_W-1:0] PIN_RESET = 7'h1a;

    // ---------------------------------------------------------------
    // Coding and bias
    // ---------------------------------------------------------------
    localparam logic FMT_OFFSET_BIN = 1'h0;
    localparam logic FMT_TWOS_COMP  = 1'h1;

    localparam logic [1:0] BIAS_OFF    = 2'h0;
    localparam logic [1:0] BIAS_50UA   = 2'h1;
    localparam logic [1:0] BIAS_500UA  = 2'h2;
    localparam logic [1:0] BIAS_1MA    = 2'h3;

    // One-hot legs of the common-mode buffer bias.
    localparam logic [2:0] LEG_NONE    = 3'h0;
    localparam logic [2:0] LEG_50UA    = 3'h1;
    localparam logic [2:0] LEG_500UA   = 3'h2;
    localparam logic [2:0] LEG_1MA     = 3'h4;

    // ---------------------------------------------------------------
    // Start-up times, in sample clock cycles
    // ---------------------------------------------------------------
    localparam int WAKE_W          = 10;
    localparam int PD_WAKE_CYCLES  = 900;
    localparam int SLP_WAKE_CYCLES = 20;

    typedef enum logic [3:0] {
        APC_ST_POWER_DOWN = 4'h1,
        APC_ST_SLEEP      = 4'h2,
        APC_ST_WAKE       = 4'h4,
        APC_ST_ACTIVE     = 4'h8
    } apc_state_e;

endpackage

`default_nettype wire

// File: rtl/apc_port.sv
`timescale 1ns/10ps
`default_nettype none

module apc_port
    import apc_pkg::*;
#(
    parameter int PD_WAKE  = PD_WAKE_CYCLES,
    parameter int SLP_WAKE = SLP_WAKE_CYCLES
) (
    // System clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // Static control pins
    input  wire logic                power_down_n,
    input  wire logic                sleep_n,
    input  wire logic                data_format_select,
    input  wire logic                output_enable_n,
    input  wire logic                sync_clock_out_enable,
    input  wire logic                common_mode_buffer_bias_hi,
    input  wire logic                common_mode_buffer_bias_lo,
    // Sample clock and converter core result
    input  wire logic                sample_clock_pos,
    input  wire logic [SAMPLE_W-1:0] conv_word,
    input  wire logic                conv_over_range,
    // Parallel output port
    output logic      [SAMPLE_W-1:0] sample_word,
    output logic                     over_range_flag,
    output logic                     sample_word_oe,
    output logic                     sync_clock_out,
    output logic                     sync_clock_out_oe,
    // Mode and bias status
    output logic      [2:0]          cm_bias_leg,
    output logic                     samples_valid,
    output logic      [3:0]          chip_state
);

    // ---------------------------------------------------------------
    // Control pin filtering
    // ---------------------------------------------------------------
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s1_r;
    logic [PIN_W-1:0] pin_s2_r;
    logic [PIN_W-1:0] pin_s3_r;
    logic [PIN_W-1:0] pin_r;
    logic [PIN_W-1:0] pin_nxt;

    assign pin_raw = {common_mode_buffer_bias_hi, common_mode_buffer_bias_lo,
                      sync_clock_out_enable, output_enable_n,
                      data_format_select, sleep_n, power_down_n};
    // A change is taken only once the second and third stages agree.
    assign pin_nxt = (pin_s2_r & pin_s3_r) | (pin_r & (pin_s2_r ^ pin_s3_r));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_s1_r <= PIN_RESET;
            pin_s2_r <= PIN_RESET;
            pin_s3_r <= PIN_RESET;
            pin_r    <= PIN_RESET;
        end else begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_r    <= pin_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Chip mode
    // ---------------------------------------------------------------
    apc_state_e state_r;
    apc_state_e state_nxt;
    logic       ready_c1_r;
    logic       ready_c2_r;
    logic       ready_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            APC_ST_POWER_DOWN: begin
                if (pin_r[PIN_PD]) begin
                    state_nxt = APC_ST_WAKE;
                end
            end
            APC_ST_SLEEP: begin
                if (pin_r[PIN_SLP]) begin
                    state_nxt = APC_ST_WAKE;
                end
            end
            APC_ST_WAKE: begin
                if (ready_c2_r) begin
                    state_nxt = APC_ST_ACTIVE;
                end
            end
            APC_ST_ACTIVE: begin
                if (!ready_c2_r) begin
                    state_nxt = APC_ST_WAKE;
                end
            end
            default: begin
                state_nxt = APC_ST_POWER_DOWN;
            end
        endcase
        if (!pin_r[PIN_PD]) begin
            state_nxt = APC_ST_POWER_DOWN;
        end else if (!pin_r[PIN_SLP]) begin
            state_nxt = APC_ST_SLEEP;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= APC_ST_POWER_DOWN;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ready_c1_r <= 1'h0;
            ready_c2_r <= 1'h0;
        end else begin
            ready_c1_r <= ready_r;
            ready_c2_r <= ready_c1_r;
        end
    end

    assign chip_state    = state_r;
    assign samples_valid = (state_r == APC_ST_ACTIVE);

    // ---------------------------------------------------------------
    // Drivers and bias
    // ---------------------------------------------------------------
    logic [2:0] leg_nxt;

    always_comb begin
        case ({pin_r[PIN_BHI], pin_r[PIN_BLO]})
            BIAS_50UA:  leg_nxt = LEG_50UA;
            BIAS_500UA: leg_nxt = LEG_500UA;
            BIAS_1MA:   leg_nxt = LEG_1MA;
            default:    leg_nxt = LEG_NONE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cm_bias_leg       <= LEG_NONE;
            sample_word_oe    <= 1'h0;
            sync_clock_out_oe <= 1'h0;
        end else begin
            // bias decode, buffer off in power-down
            cm_bias_leg       <= pin_r[PIN_PD] ? leg_nxt : LEG_NONE;
            sample_word_oe    <= !pin_r[PIN_OE];
            sync_clock_out_oe <= !pin_r[PIN_CKEN];
        end
    end

    // ---------------------------------------------------------------
    // Sample clock domain
    // ---------------------------------------------------------------
    logic              rst_l1_r;
    logic              rst_l2_r;
    logic              pd_l1_r;
    logic              pd_l2_r;
    logic              slp_l1_r;
    logic              slp_l2_r;
    logic              fmt_l1_r;
    logic              fmt_l2_r;
    logic              was_pd_r;
    logic              run_r;
    logic [WAKE_W-1:0] wake_cnt_r;
    logic [WAKE_W-1:0] wake_lim;
    logic              link_srst;

    always_ff @(posedge sample_clock_pos) begin
        rst_l1_r <= rst_n;
        rst_l2_r <= rst_l1_r;
        pd_l1_r  <= !pin_r[PIN_PD];
        pd_l2_r  <= pd_l1_r;
        slp_l1_r <= !pin_r[PIN_SLP];
        slp_l2_r <= slp_l1_r;
        fmt_l1_r <= pin_r[PIN_FMT];
        fmt_l2_r <= fmt_l1_r;
    end

    assign link_srst = !rst_l2_r || pd_l2_r;
    assign wake_lim  = was_pd_r ? WAKE_W'(PD_WAKE - 1) : WAKE_W'(SLP_WAKE - 1);

    always_ff @(posedge sample_clock_pos) begin
        if (link_srst) begin
            wake_cnt_r <= '0;
            was_pd_r   <= 1'h1;
            ready_r    <= 1'h0;
        end else if (slp_l2_r) begin
            wake_cnt_r <= '0;
            ready_r    <= 1'h0;
        end else if (!ready_r) begin
            wake_cnt_r <= wake_cnt_r + WAKE_W'(1);
            if (wake_cnt_r == wake_lim) begin
                ready_r  <= 1'h1;
                was_pd_r <= 1'h0;
            end
        end
    end

    always_ff @(posedge sample_clock_pos) begin
        if (link_srst) begin
            sample_word     <= '0;
            over_range_flag <= 1'h0;
            run_r           <= 1'h0;
        end else begin
            run_r <= 1'h1;
            if (ready_r && !slp_l2_r) begin
                // coding, bit 0 is the LSB
                sample_word     <= {conv_word[SAMPLE_W-1] ^ fmt_l2_r,
                                    conv_word[SAMPLE_W-2:0]};
                over_range_flag <= conv_over_range;
            end
        end
    end

    // forwarded clock, held low in power-down
    assign sync_clock_out = sample_clock_pos & run_r;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    sequence s_pd_exit;
        $fell(pd_l2_r) && rst_l2_r;
    endsequence

    sequence s_slp_exit;
        $fell(slp_l2_r) && !was_pd_r && !pd_l2_r;
    endsequence

    a_pd_state: assert property (
        @(posedge clk) disable iff (!rst_n)
        !pin_r[PIN_PD] |=> (state_r == APC_ST_POWER_DOWN) && !samples_valid)
        else $error("power-down did not reach its state");

    a_oe_follow: assert property (
        @(posedge clk) disable iff (!rst_n)
        (pin_s2_r[PIN_OE] == pin_s3_r[PIN_OE]) |=> ##1
            (sample_word_oe == !$past(pin_s3_r[PIN_OE], 2)))
        else $error("data driver enable wrong");

    a_ck_oe: assert property (
        @(posedge clk) disable iff (!rst_n)
        (pin_r[PIN_CKEN] && $stable(pin_r[PIN_CKEN])) |=> !sync_clock_out_oe)
        else $error("sync clock driven while disabled");

    a_bias_dec: assert property (
        @(posedge clk) disable iff (!rst_n)
        (pin_r[PIN_PD] && pin_r[PIN_BHI] && !pin_r[PIN_BLO])
            |=> cm_bias_leg == LEG_500UA)
        else $error("bias decode wrong");

    a_pd_zero: assert property (
        @(posedge sample_clock_pos) disable iff (!rst_l2_r)
        pd_l2_r |=> (sample_word == '0) && !over_range_flag && !run_r)
        else $error("outputs not cleared in power-down");

    a_pd_wake: assert property (
        @(posedge sample_clock_pos) disable iff (!rst_l2_r)
        s_pd_exit |-> ##[1:901] (ready_r || slp_l2_r || pd_l2_r))
        else $error("power-down start-up too slow");

    a_slp_wake: assert property (
        @(posedge sample_clock_pos) disable iff (!rst_l2_r)
        s_slp_exit |-> ##[1:21] (ready_r || slp_l2_r || pd_l2_r))
        else $error("sleep start-up too slow");

    a_word_fmt: assert property (
        @(posedge sample_clock_pos) disable iff (link_srst)
        (ready_r && !slp_l2_r && fmt_l2_r) |=>
            sample_word == {~$past(conv_word[SAMPLE_W-1]),
                            $past(conv_word[SAMPLE_W-2:0])})
        else $error("two's complement coding wrong");

    a_over_range_flag_flag: assert property (
        @(posedge sample_clock_pos) disable iff (link_srst)
        (ready_r && !slp_l2_r) |=> over_range_flag == $past(conv_over_range))
        else $error("range flag does not follow sample");

endmodule

`default_nettype wire

// File: tb/apc_capture_model.sv
`timescale 1ns/10ps
`default_nettype none

module apc_capture_model
    import apc_pkg::*;
(
    // Pins seen at the board
    input  wire logic [SAMPLE_W-1:0] data_pins,
    input  wire logic                flag_pin,
    input  wire logic                sync_pin,
    // Captured sample
    output logic      [SAMPLE_W-1:0] cap_word,
    output logic                     cap_flag
);
    // Capturing midway through the sync period keeps clear of the
    // launching edge of the data.
    // capture on sync clock
    always_ff @(negedge sync_pin) begin
        cap_word <= data_pins;
        cap_flag <= flag_pin;
    end
endmodule

`default_nettype wire

// File: tb/adc_pin_control_output_port_tb.sv
`timescale 1ns/10ps
`default_nettype none

module adc_pin_control_output_port_tb;
    import apc_pkg::*;
    localparam int PDW = 30;
    localparam int SLW = 20;
    localparam int LIM_PD = (PDW + 4) * 3 / 2 + 8;
    localparam int LIM_SL = (SLW + 4) * 3 / 2 + 8;
    logic                clk, rst_n, power_down_n, sleep_n, fmt, oe_n;
    logic                ck_en_n, b_hi, b_lo, sclk, conv_or;
    logic [SAMPLE_W-1:0] conv_word, sample_word, cap_word;
    logic                over_range_flag, sample_word_oe, sync_clock_out;
    logic                sync_clock_out_oe, samples_valid, cap_flag;
    logic [2:0]          cm_bias_leg;
    logic [3:0]          chip_state;
    wire logic [SAMPLE_W-1:0] data_pins;
    wire logic                flag_pin, sync_pin;
    int                  n_errors = 0;
    int                  num_checks = 0;
    logic [SAMPLE_W-1:0] vals [4] = '{10'h000, 10'h3ff, 10'h200, 10'h155};
    logic [2:0]          legs [4] = '{LEG_NONE, LEG_50UA, LEG_500UA, LEG_1MA};

    // Released lines show the inverse of the last value; sync stands low.
    assign data_pins = sample_word_oe ? sample_word : ~sample_word;
    assign flag_pin  = sample_word_oe ? over_range_flag : ~over_range_flag;
    assign sync_pin  = sync_clock_out_oe ? sync_clock_out : 1'h0;

    apc_port #(.PD_WAKE(PDW), .SLP_WAKE(SLW)) DUT (
        .clk(clk), .rst_n(rst_n), .power_down_n(power_down_n),
        .sleep_n(sleep_n), .data_format_select(fmt),
        .output_enable_n(oe_n), .sync_clock_out_enable(ck_en_n),
        .common_mode_buffer_bias_hi(b_hi), .common_mode_buffer_bias_lo(b_lo),
        .sample_clock_pos(sclk), .conv_word(conv_word),
        .conv_over_range(conv_or), .sample_word(sample_word),
        .over_range_flag(over_range_flag), .sample_word_oe(sample_word_oe),
        .sync_clock_out(sync_clock_out),
        .sync_clock_out_oe(sync_clock_out_oe), .cm_bias_leg(cm_bias_leg),
        .samples_valid(samples_valid), .chip_state(chip_state));

    apc_capture_model CAP (
        .data_pins(data_pins), .flag_pin(flag_pin), .sync_pin(sync_pin),
        .cap_word(cap_word), .cap_flag(cap_flag));

    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    initial begin
        sclk = 1'h0;
        #3;
        forever #6 sclk = ~sclk;
    end

    // ---------------------------------------------------------------
    // Access tasks
    // ---------------------------------------------------------------
    task automatic test_done();
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic pins(input logic pd, sl, fm, oe, ck, input logic [1:0] b);
        @(posedge clk);
        power_down_n <= pd;
        sleep_n      <= sl;
        fmt          <= fm;
        oe_n         <= oe;
        ck_en_n      <= ck;
        {b_hi, b_lo} <= b;
        tick(8);
    endtask

    task automatic put_conv(input logic [9:0] v, input logic f);
        @(posedge sclk);
        conv_word <= v;
        conv_or   <= f;
    endtask

    task automatic wait_valid(input int lim);
        int n;
        n = 0;
        while (samples_valid !== 1'h1) begin
            tick(1);
            n++;
            if (n > lim) begin
                n_errors++;
                $display("BAD t=%0t got=%h exp=%h", $time, n, lim);
                test_done();
            end
        end
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        rst_n        <= 1'h0;
        power_down_n <= 1'h0;
        sleep_n      <= 1'h1;
        fmt          <= 1'h0;
        oe_n         <= 1'h0;
        ck_en_n      <= 1'h0;
        {b_hi, b_lo} <= 2'h3;
        conv_word    <= 10'h000;
        conv_or      <= 1'h1;
        tick(6);
        @(posedge clk);
        rst_n <= 1'h1;
        tick(8);
        chk(10'(chip_state), 10'h001);
        chk(sample_word, 10'h000);
        chk(10'(over_range_flag), 10'h000);
        pins(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 2'h3);
        chk(10'(chip_state), 10'h004);
        wait_valid(LIM_PD);
        chk(10'(chip_state), 10'h008);
        for (int f = 0; f < 2; f++) begin
            for (int i = 0; i < 4; i++) begin
                pins(1'h1, 1'h1, f[0], 1'h0, 1'h0, 2'h3);
                put_conv(vals[i], i[0]);
                tick(10);
                chk(cap_word, f ? vals[i] ^ 10'h200 : vals[i]);
                chk(10'(cap_flag), 10'(i[0]));
            end
        end
        for (int b = 0; b < 4; b++) begin
            pins(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, b[1:0]);
            chk(10'(cm_bias_leg), 10'(legs[b]));
        end
        pins(1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 2'h3);
        chk(10'(sample_word_oe), 10'h000);
        chk(10'(sync_clock_out_oe), 10'h000);
        pins(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 2'h3);
        chk(10'(sample_word_oe), 10'h001);
        chk(10'(sync_clock_out_oe), 10'h001);
        put_conv(10'h0aa, 1'h0);
        tick(10);
        pins(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 2'h3);
        chk(10'(chip_state), 10'h002);
        chk(10'(samples_valid), 10'h000);
        put_conv(10'h111, 1'h1);
        tick(10);
        chk(sample_word, 10'h0aa);
        pins(1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 2'h3);
        wait_valid(LIM_SL);
        tick(10);
        chk(sample_word, 10'h111);
        pins(1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 2'h3);
        tick(6);
        chk(10'(chip_state), 10'h001);
        chk(sample_word, 10'h000);
        chk(10'(over_range_flag), 10'h000);
        chk(10'(sync_clock_out), 10'h000);
        test_done();
    end
endmodule

`default_nettype wire
